// [sdbba_pkg.sv]
// Constants, field positions and types shared by the SDRAM bank and burst model
package sdbba_pkg;
    // Array geometry of the x16 organisation
    localparam int NUM_BANKS   = 4;
    localparam int NUM_ROWS    = 4096;
    localparam int NUM_COLS    = 512;
    localparam int BANK_W      = 2;
    localparam int ROW_W       = 12;
    localparam int COL_W       = 9;
    localparam int DQ_W        = 16;
    localparam int DQM_W       = 2;
    localparam int CNT_W       = 10;
    // Backing store keeps the low row and column bits only
    localparam int STORE_ROW_W = 2;
    localparam int STORE_COL_W = 6;
    localparam int STORE_W     = BANK_W + STORE_ROW_W + STORE_COL_W;
    localparam int STORE_DEPTH = 1 << STORE_W;

    // Command codes on {ras_n, cas_n, we_n}
    localparam logic [2:0] CMD_LMR = 3'h0;
    localparam logic [2:0] CMD_REF = 3'h1;
    localparam logic [2:0] CMD_PRE = 3'h2;
    localparam logic [2:0] CMD_ACT = 3'h3;
    localparam logic [2:0] CMD_WR  = 3'h4;
    localparam logic [2:0] CMD_RD  = 3'h5;
    localparam logic [2:0] CMD_BST = 3'h6;

    localparam int PRECHARGE_SCOPE_POS = 10;

    // Burst count setting codes
    localparam logic [2:0] BCS_FULL_PAGE = 3'h7;

    // Register map
    localparam int         AXI_ADDR_W   = 4;
    localparam logic [3:0] REG_CTRL_OFS = 4'h0;
    localparam logic [3:0] REG_STAT_OFS = 4'h4;
    localparam int CTRL_BCS_LSB   = 0;
    localparam int CTRL_ILV_POS   = 3;
    localparam int CTRL_CL_LSB    = 4;
    localparam int CTRL_AUTO_POS  = 8;
    localparam logic [31:0] CTRL_RESET = 32'h0000_0023;
    localparam logic [31:0] CTRL_MASK  = 32'h0000_013f;
    localparam int STAT_OPEN_LSB   = 0;
    localparam int STAT_PWR_LSB    = 4;
    localparam int STAT_BURST_POS  = 9;
    localparam int STAT_WRITE_POS  = 10;
    localparam int STAT_REFCNT_LSB = 16;
    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef enum logic [4:0] {
        PWR_RUN     = 5'h01,
        PWR_PREPD   = 5'h02,
        PWR_ACTPD   = 5'h04,
        PWR_SUSPEND = 5'h08,
        PWR_SELFREF = 5'h10
    } sdbba_pwr_t;
endpackage

// [sdbba_axil.sv]
// AXI4-Lite slave holding the control register and returning the status word
`timescale 1ns/10ps
module sdbba_axil (
    input  wire logic        clk,      // System clock
    input  wire logic        rst_n,    // Synchronous reset, active low
    input  wire logic [3:0]  awaddr,   // Write address
    input  wire logic        awvalid,  // Write address valid
    output logic             awready,  // Write address ready
    input  wire logic [31:0] wdata,    // Write data
    input  wire logic [3:0]  wstrb,    // Write byte strobes
    input  wire logic        wvalid,   // Write data valid
    output logic             wready,   // Write data ready
    output logic [1:0]       bresp,    // Write response
    output logic             bvalid,   // Write response valid
    input  wire logic        bready,   // Write response ready
    input  wire logic [3:0]  araddr,   // Read address
    input  wire logic        arvalid,  // Read address valid
    output logic             arready,  // Read address ready
    output logic [31:0]      rdata,    // Read data
    output logic [1:0]       rresp,    // Read response
    output logic             rvalid,   // Read data valid
    input  wire logic        rready,   // Read data ready
    output logic [31:0]      ctrl_o,   // Control register contents
    input  wire logic [31:0] status_i  // Live status word
);
    logic        aw_hold_q;
    logic [3:0]  awaddr_q;
    logic        w_hold_q;
    logic [31:0] wdata_q;
    logic [3:0]  wstrb_q;
    logic        bvalid_q;
    logic [1:0]  bresp_q;
    logic        rvalid_q;
    logic [31:0] rdata_q;
    logic [1:0]  rresp_q;
    logic [31:0] ctrl_q;
    logic        do_write;

    assign awready  = !aw_hold_q && !bvalid_q;
    assign wready   = !w_hold_q && !bvalid_q;
    assign arready  = !rvalid_q;
    assign bvalid   = bvalid_q;
    assign bresp    = bresp_q;
    assign rvalid   = rvalid_q;
    assign rdata    = rdata_q;
    assign rresp    = rresp_q;
    assign ctrl_o   = ctrl_q;
    assign do_write = aw_hold_q && w_hold_q;

    // Address and data are caught in either order
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            aw_hold_q <= 1'b0;
            awaddr_q  <= 4'h0;
            w_hold_q  <= 1'b0;
            wdata_q   <= 32'h0000_0000;
            wstrb_q   <= 4'h0;
        end else if (do_write) begin
            aw_hold_q <= 1'b0;
            w_hold_q  <= 1'b0;
        end else begin
            if (awvalid && awready) begin
                aw_hold_q <= 1'b1;
                awaddr_q  <= awaddr;
            end
            if (wvalid && wready) begin
                w_hold_q <= 1'b1;
                wdata_q  <= wdata;
                wstrb_q  <= wstrb;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            ctrl_q   <= sdbba_pkg::CTRL_RESET;
            bvalid_q <= 1'b0;
            bresp_q  <= sdbba_pkg::RESP_OKAY;
        end else if (do_write) begin
            bvalid_q <= 1'b1;
            if (awaddr_q == sdbba_pkg::REG_CTRL_OFS) begin
                for (int i = 0; i < 4; i++) begin
                    if (wstrb_q[i]) begin
                        ctrl_q[i*8 +: 8] <= wdata_q[i*8 +: 8] & sdbba_pkg::CTRL_MASK[i*8 +: 8];
                    end
                end
                bresp_q <= sdbba_pkg::RESP_OKAY;
            end else if (awaddr_q == sdbba_pkg::REG_STAT_OFS) begin
                bresp_q <= sdbba_pkg::RESP_OKAY;
            end else begin
                bresp_q <= sdbba_pkg::RESP_SLVERR;
            end
        end else if (bvalid_q && bready) begin
            bvalid_q <= 1'b0;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            rvalid_q <= 1'b0;
            rdata_q  <= 32'h0000_0000;
            rresp_q  <= sdbba_pkg::RESP_OKAY;
        end else if (arvalid && arready) begin
            rvalid_q <= 1'b1;
            if (araddr == sdbba_pkg::REG_CTRL_OFS) begin
                rdata_q <= ctrl_q;
                rresp_q <= sdbba_pkg::RESP_OKAY;
            end else if (araddr == sdbba_pkg::REG_STAT_OFS) begin
                rdata_q <= status_i;
                rresp_q <= sdbba_pkg::RESP_OKAY;
            end else begin
                rdata_q <= 32'h0000_0000;
                rresp_q <= sdbba_pkg::RESP_SLVERR;
            end
        end else if (rvalid_q && rready) begin
            rvalid_q <= 1'b0;
        end
    end
endmodule // sdbba_axil

// [sdbba_top.sv]
// SDRAM bank, burst and power-state model as seen at its command pins
// Notes on behaviour
// - Every pin is captured only at the rising system clock edge.
// - Four banks of 4096 rows; x16 rows hold 512 sixteen-bit columns.
// - Activate takes bank bits as bank and twelve address bits as row.
// - Read or write takes its registered address as the burst start column.
// - Burst lengths one, two, four, eight or full page; terminate stops early.
// - A burst runs its programmed length in the programmed column order, except full page, which wraps sequentially until stopped.
// - Auto precharge closes the row by itself when the burst ends.
// - A new column command is accepted on every clock cycle.
// - One bank may precharge while another bank is accessed.
// - Successive burst columns are generated internally from the start column.
// - Auto refresh and power-down modes are provided.
// - Chip select high masks commands; running bursts and data mask continue.
// - Scope bit asks auto precharge on access, all banks on precharge.
// - Mask high blocks write data; on reads both mask bits high float output two clocks later.
// - Clock gate low freezes clocking: power-down, self refresh or suspend.
//
// Implementation choices: the AXI4-Lite interface to the registers and the placing of the registers.
`timescale 1ns/10ps
module sdbba_top (
    input  wire logic        CLK_SYS,        // System clock, 20 MHz
    input  wire logic        RST_N,          // Synchronous reset, active low
    input  wire logic        CKE,            // Clock gate
    input  wire logic        CS_N,           // Chip select, active low
    input  wire logic        RAS_N,          // Row strobe, active low
    input  wire logic        CAS_N,          // Column strobe, active low
    input  wire logic        WE_N,           // Write enable, active low
    input  wire logic [1:0]  BA,             // Bank select
    input  wire logic [11:0] ADDR,           // Row or column address
    input  wire logic [1:0]  DQM,            // Byte masks, high byte in bit 1
    input  wire logic [15:0] DQ_I,           // Data pin level in
    output logic [15:0]      DQ_O,           // Data pin drive value
    output logic             DQ_OE,          // Data pin drive enable
    input  wire logic [3:0]  S_AXI_AWADDR,   // Write address
    input  wire logic        S_AXI_AWVALID,  // Write address valid
    output logic             S_AXI_AWREADY,  // Write address ready
    input  wire logic [31:0] S_AXI_WDATA,    // Write data
    input  wire logic [3:0]  S_AXI_WSTRB,    // Write strobes
    input  wire logic        S_AXI_WVALID,   // Write data valid
    output logic             S_AXI_WREADY,   // Write data ready
    output logic [1:0]       S_AXI_BRESP,    // Write response
    output logic             S_AXI_BVALID,   // Write response valid
    input  wire logic        S_AXI_BREADY,   // Write response ready
    input  wire logic [3:0]  S_AXI_ARADDR,   // Read address
    input  wire logic        S_AXI_ARVALID,  // Read address valid
    output logic             S_AXI_ARREADY,  // Read address ready
    output logic [31:0]      S_AXI_RDATA,    // Read data
    output logic [1:0]       S_AXI_RRESP,    // Read response
    output logic             S_AXI_RVALID,   // Read data valid
    input  wire logic        S_AXI_RREADY    // Read data ready
);
    // Length of a burst for a burst count setting
    function automatic logic [9:0] burst_len(input logic [2:0] bcs);
        logic [9:0] len;
        len = 10'h001;
        case (bcs)
            3'h0:    len = 10'h001;
            3'h1:    len = 10'h002;
            3'h2:    len = 10'h004;
            3'h3:    len = 10'h008;
            default: len = 10'h200;
        endcase
        return len;
    endfunction

    // Column of the n-th beat: wraps in its aligned block, interleave uses xor
    function automatic logic [8:0] beat_col(input logic [8:0] start, input logic [9:0] n,
                                            input logic [9:0] len, input logic ilv);
        logic [8:0] msk;
        logic [8:0] off;
        msk = len[8:0] - 9'h001;
        if (ilv) begin
            off = start ^ n[8:0];
        end else begin
            off = start + n[8:0];
        end
        return (start & ~msk) | (off & msk);
    endfunction

    function automatic logic [9:0] store_idx(input logic [1:0] bank, input logic [11:0] row,
                                             input logic [8:0] col);
        return {bank, row[1:0], col[5:0]};
    endfunction

    logic [31:0] ctrl;
    logic [31:0] status;
    logic [2:0]  bcs;
    logic        ilv;
    logic [1:0]  cas_lat;
    logic        automotive_grade;
    logic [9:0]  cfg_len;
    logic        full_page;

    logic        cke_q;
    logic        en;
    logic        cmd_ok;
    logic [2:0]  cmd;
    logic        is_act;
    logic        is_rd;
    logic        is_wr;
    logic        is_pre;
    logic        is_bst;
    logic        is_ref;
    logic        start_rw;

    logic [3:0]  row_open_q;
    logic [11:0] row_q [4];
    logic        burst_q;
    logic        wr_q;
    logic        ap_q;
    logic [1:0]  bank_q;
    logic [8:0]  start_q;
    logic [9:0]  cnt_q;
    logic [9:0]  len_q;
    logic        ilv_q;

    logic        acc_v;
    logic        acc_wr;
    logic        acc_ap;
    logic [1:0]  acc_bank;
    logic [8:0]  acc_col;
    logic [9:0]  acc_n;
    logic        acc_last;
    logic        ap_close;
    logic [1:0]  ap_bank;

    logic [15:0] mem [sdbba_pkg::STORE_DEPTH];
    logic [9:0]  acc_idx;
    logic        d1_v_q;
    logic        d2_v_q;
    logic [15:0] d1_q;
    logic [15:0] d2_q;
    logic [1:0]  dqm_q;
    logic        out_v;
    logic [15:0] out_d;
    logic [15:0] dq_o_q;
    logic        dq_oe_q;

    sdbba_pkg::sdbba_pwr_t pwr_q;
    logic [15:0] refcnt_q;

    assign bcs              = ctrl[sdbba_pkg::CTRL_BCS_LSB +: 3];
    assign ilv              = ctrl[sdbba_pkg::CTRL_ILV_POS];
    assign cas_lat          = ctrl[sdbba_pkg::CTRL_CL_LSB +: 2];
    assign automotive_grade = ctrl[sdbba_pkg::CTRL_AUTO_POS];
    assign cfg_len          = burst_len(bcs);
    assign full_page        = (bcs == sdbba_pkg::BCS_FULL_PAGE);

    // Clock gate sampled at one edge freezes the next one
    always_ff @(posedge CLK_SYS) begin
        if (!RST_N) begin
            cke_q <= 1'b1;
        end else begin
            cke_q <= CKE;
        end
    end
    assign en = cke_q;

    // Command decode; chip select high masks every command
    assign cmd      = {RAS_N, CAS_N, WE_N};
    assign cmd_ok   = en && !CS_N;
    assign is_act   = cmd_ok && (cmd == sdbba_pkg::CMD_ACT);
    assign is_rd    = cmd_ok && (cmd == sdbba_pkg::CMD_RD);
    assign is_wr    = cmd_ok && (cmd == sdbba_pkg::CMD_WR);
    assign is_pre   = cmd_ok && (cmd == sdbba_pkg::CMD_PRE);
    assign is_bst   = cmd_ok && (cmd == sdbba_pkg::CMD_BST);
    assign is_ref   = !CS_N && (cmd == sdbba_pkg::CMD_REF);
    assign start_rw = (is_rd || is_wr) && row_open_q[BA];

    // Access performed at this edge: new command first, then burst beat
    always_comb begin
        acc_v    = 1'b0;
        acc_wr   = wr_q;
        acc_ap   = ap_q;
        acc_bank = bank_q;
        acc_col  = start_q;
        acc_n    = cnt_q;
        acc_last = 1'b0;
        if (start_rw) begin
            acc_v    = 1'b1;
            acc_wr   = is_wr;
            acc_ap   = ADDR[sdbba_pkg::PRECHARGE_SCOPE_POS];
            acc_bank = BA;
            acc_col  = ADDR[8:0];
            acc_n    = 10'h000;
            acc_last = !full_page && (cfg_len == 10'h001);
        end else if (burst_q && en && !is_bst) begin
            acc_v    = 1'b1;
            acc_col  = beat_col(start_q, cnt_q, len_q, ilv_q);
            acc_last = (len_q != 10'h200 || !full_page) && (cnt_q == len_q - 10'h001);
        end
    end

    // Auto precharge on natural end, interruption or terminate
    always_comb begin
        ap_close = 1'b0;
        ap_bank  = bank_q;
        if (acc_v && acc_last && acc_ap) begin
            ap_close = 1'b1;
            ap_bank  = acc_bank;
        end else if (burst_q && ap_q && (start_rw || is_bst)) begin
            ap_close = 1'b1;
            ap_bank  = bank_q;
        end
    end

    // Per-bank row state; other banks stay usable while one closes
    always_ff @(posedge CLK_SYS) begin
        if (!RST_N) begin
            row_open_q <= 4'h0;
            for (int b = 0; b < sdbba_pkg::NUM_BANKS; b++) begin
                row_q[b] <= 12'h000;
            end
        end else begin
            if (ap_close) begin
                row_open_q[ap_bank] <= 1'b0;
            end
            if (is_pre) begin
                if (ADDR[sdbba_pkg::PRECHARGE_SCOPE_POS]) begin
                    row_open_q <= 4'h0;
                end else begin
                    row_open_q[BA] <= 1'b0;
                end
            end
            if (is_act) begin
                row_open_q[BA] <= 1'b1;
                row_q[BA]      <= ADDR;
            end
        end
    end

    // Burst sequencer
    always_ff @(posedge CLK_SYS) begin
        if (!RST_N) begin
            burst_q <= 1'b0;
            wr_q    <= 1'b0;
            ap_q    <= 1'b0;
            bank_q  <= 2'h0;
            start_q <= 9'h000;
            cnt_q   <= 10'h000;
            len_q   <= 10'h001;
            ilv_q   <= 1'b0;
        end else if (start_rw) begin
            burst_q <= !acc_last;
            wr_q    <= is_wr;
            ap_q    <= ADDR[sdbba_pkg::PRECHARGE_SCOPE_POS];
            bank_q  <= BA;
            start_q <= ADDR[8:0];
            cnt_q   <= 10'h001;
            len_q   <= cfg_len;
            ilv_q   <= ilv && !full_page;
        end else if (is_bst) begin
            burst_q <= 1'b0;
        end else if (acc_v) begin
            burst_q <= !acc_last;
            cnt_q   <= (cnt_q == 10'h1ff) ? 10'h000 : cnt_q + 10'h001;
        end
    end

    assign acc_idx = store_idx(acc_bank, row_q[acc_bank], acc_col);

    // Write beats, each byte lane gated by its mask
    always_ff @(posedge CLK_SYS) begin
        if (acc_v && acc_wr) begin
            if (!DQM[0]) begin
                mem[acc_idx][7:0] <= DQ_I[7:0];
            end
            if (!DQM[1]) begin
                mem[acc_idx][15:8] <= DQ_I[15:8];
            end
        end
    end

    // Read pipeline for the column latency, frozen while suspended
    always_ff @(posedge CLK_SYS) begin
        if (!RST_N) begin
            d1_v_q <= 1'b0;
            d2_v_q <= 1'b0;
            d1_q   <= 16'h0000;
            d2_q   <= 16'h0000;
        end else if (en) begin
            d1_v_q <= acc_v && !acc_wr;
            d1_q   <= mem[acc_idx];
            d2_v_q <= d1_v_q;
            d2_q   <= d1_q;
        end
    end

    always_comb begin
        case (cas_lat)
            2'h1: begin
                out_v = acc_v && !acc_wr;
                out_d = mem[acc_idx];
            end
            2'h3: begin
                out_v = d2_v_q;
                out_d = d2_q;
            end
            default: begin
                out_v = d1_v_q;
                out_d = d1_q;
            end
        endcase
    end

    // Mask at edge n floats the data driven after edge n+1
    always_ff @(posedge CLK_SYS) begin
        if (!RST_N) begin
            dqm_q   <= 2'h0;
            dq_o_q  <= 16'h0000;
            dq_oe_q <= 1'b0;
        end else begin
            dqm_q <= DQM;
            if (en) begin
                dq_o_q  <= out_d;
                dq_oe_q <= out_v && !(&dqm_q);
            end
        end
    end
    assign DQ_O  = dq_o_q;
    assign DQ_OE = dq_oe_q;

    // Power states and refresh counting
    always_ff @(posedge CLK_SYS) begin
        if (!RST_N) begin
            pwr_q    <= sdbba_pkg::PWR_RUN;
            refcnt_q <= 16'h0000;
        end else begin
            if (is_ref && en && row_open_q == 4'h0 && !burst_q &&
                (CKE || !automotive_grade)) begin
                refcnt_q <= refcnt_q + 16'h0001;
            end
            case (pwr_q)
                sdbba_pkg::PWR_SELFREF: begin
                    if (CKE) begin
                        pwr_q <= sdbba_pkg::PWR_RUN;
                    end
                end
                default: begin
                    if (CKE) begin
                        pwr_q <= sdbba_pkg::PWR_RUN;
                    end else if (burst_q) begin
                        pwr_q <= sdbba_pkg::PWR_SUSPEND;
                    end else if (row_open_q != 4'h0) begin
                        pwr_q <= sdbba_pkg::PWR_ACTPD;
                    end else if (en && is_ref && !automotive_grade) begin
                        pwr_q <= sdbba_pkg::PWR_SELFREF;
                    end else if (pwr_q != sdbba_pkg::PWR_SELFREF) begin
                        pwr_q <= sdbba_pkg::PWR_PREPD;
                    end
                end
            endcase
        end
    end

    always_comb begin
        status = 32'h0000_0000;
        status[sdbba_pkg::STAT_OPEN_LSB +: 4]    = row_open_q;
        status[sdbba_pkg::STAT_PWR_LSB +: 5]     = pwr_q;
        status[sdbba_pkg::STAT_BURST_POS]        = burst_q;
        status[sdbba_pkg::STAT_WRITE_POS]        = wr_q;
        status[sdbba_pkg::STAT_REFCNT_LSB +: 16] = refcnt_q;
    end

    sdbba_axil u_regs (
        .clk      (CLK_SYS),
        .rst_n    (RST_N),
        .awaddr   (S_AXI_AWADDR),
        .awvalid  (S_AXI_AWVALID),
        .awready  (S_AXI_AWREADY),
        .wdata    (S_AXI_WDATA),
        .wstrb    (S_AXI_WSTRB),
        .wvalid   (S_AXI_WVALID),
        .wready   (S_AXI_WREADY),
        .bresp    (S_AXI_BRESP),
        .bvalid   (S_AXI_BVALID),
        .bready   (S_AXI_BREADY),
        .araddr   (S_AXI_ARADDR),
        .arvalid  (S_AXI_ARVALID),
        .arready  (S_AXI_ARREADY),
        .rdata    (S_AXI_RDATA),
        .rresp    (S_AXI_RRESP),
        .rvalid   (S_AXI_RVALID),
        .rready   (S_AXI_RREADY),
        .ctrl_o   (ctrl),
        .status_i (status)
    );
endmodule // sdbba_top

// [sdbba_ctl_model.sv]
// Memory controller model driving the command pins
`timescale 1ns/10ps
module sdbba_ctl_model (
    input  wire logic   CLK_SYS, // System clock
    output logic        CS_N,    // Chip select
    output logic        RAS_N,   // Row strobe
    output logic        CAS_N,   // Column strobe
    output logic        WE_N,    // Write enable
    output logic [1:0]  BA,      // Bank
    output logic [11:0] ADDR,    // Address
    output logic [1:0]  DQM,     // Byte masks
    output logic [15:0] DQ_I     // Write data
);
    initial {CS_N, RAS_N, CAS_N, WE_N, BA, ADDR, DQM, DQ_I} = {4'hf, 32'h0};
    // Callers activate a row before accessing it, except the bench's final read after auto precharge
    task cmd(input logic [2:0] op, input logic [1:0] b, input logic [11:0] a,
             input logic [1:0] m, input logic [15:0] d, input logic wr);
        @(posedge CLK_SYS);
        {CS_N, RAS_N, CAS_N, WE_N, BA, ADDR, DQM} <= {1'b0, op, b, a, m};
        DQ_I <= wr ? d : ~DQ_I;
    endtask
endmodule // sdbba_ctl_model

// [sdbba_top_checker.sv]
// Port-level assertions for the SDRAM model
`timescale 1ns/10ps
module sdbba_top_checker (
    input wire logic CLK_SYS, RST_N, CKE, CS_N, RAS_N, CAS_N, WE_N, DQ_OE,
    input wire logic S_AXI_AWVALID, S_AXI_AWREADY, S_AXI_WVALID, S_AXI_WREADY,
    input wire logic S_AXI_BVALID, S_AXI_BREADY, S_AXI_ARVALID, S_AXI_ARREADY,
    input wire logic S_AXI_RVALID, S_AXI_RREADY,
    input wire logic [1:0] DQM,
    input wire logic [15:0] DQ_O
);
    default clocking @(posedge CLK_SYS); endclocking
    default disable iff (!RST_N);
    wire rd = !CS_N && {RAS_N, CAS_N, WE_N} == sdbba_pkg::CMD_RD;
    property p_float; $past(DQM, 2) == 2'h3 && $past(CKE) && $past(CKE, 2) |-> !DQ_OE; endproperty
    property p_rdlat; $rose(DQ_OE) |-> $past(rd) || $past(rd, 2) || $past(rd, 3); endproperty
    property p_freeze; !CKE |-> ##2 $stable({DQ_OE, DQ_O}); endproperty
    // Both halves sit in their holding registers one cycle before the response rises
    property p_wresp; S_AXI_AWVALID && S_AXI_AWREADY && S_AXI_WVALID && S_AXI_WREADY
        |=> ##1 S_AXI_BVALID; endproperty
    property p_bdone; S_AXI_BVALID && S_AXI_BREADY |=> !S_AXI_BVALID; endproperty
    property p_rresp; S_AXI_ARVALID && S_AXI_ARREADY |=> S_AXI_RVALID; endproperty
    property p_rdone; S_AXI_RVALID && S_AXI_RREADY |=> !S_AXI_RVALID; endproperty
    property p_arblk; S_AXI_RVALID |-> !S_AXI_ARREADY; endproperty
    a_float: assert property (p_float) else $error("read beat not floated");
    a_rdlat: assert property (p_rdlat) else $error("drive without read");
    a_freeze: assert property (p_freeze) else $error("outputs moved while gated");
    a_wresp: assert property (p_wresp) else $error("no write response");
    a_bdone: assert property (p_bdone) else $error("write response held");
    a_rresp: assert property (p_rresp) else $error("no read response");
    a_rdone: assert property (p_rdone) else $error("read response held");
    a_arblk: assert property (p_arblk) else $error("read address taken early");
    c_rd: cover property (rd);
    c_drive: cover property ($rose(DQ_OE));
    c_gate: cover property (!CKE);
endmodule // sdbba_top_checker
bind sdbba_top sdbba_top_checker i_chk (.*);

// [test_sdram_bank_burst_access.sv]
// Self-checking bench for the SDRAM model
`timescale 1ns/10ps
module test_sdram_bank_burst_access;
    logic CLK_SYS = 0, RST_N = 0, CKE = 1, CS_N, RAS_N, CAS_N, WE_N, DQ_OE;
    logic S_AXI_AWVALID = 0, S_AXI_WVALID = 0, S_AXI_BREADY = 0, S_AXI_ARVALID = 0;
    logic S_AXI_RREADY = 0, S_AXI_AWREADY, S_AXI_WREADY, S_AXI_BVALID, S_AXI_ARREADY;
    logic S_AXI_RVALID;
    logic [3:0] S_AXI_AWADDR = 0, S_AXI_ARADDR = 0, S_AXI_WSTRB = 4'hf;
    logic [31:0] S_AXI_WDATA = 0, S_AXI_RDATA;
    logic [1:0] S_AXI_BRESP, S_AXI_RRESP, BA, DQM;
    logic [11:0] ADDR;
    logic [15:0] DQ_I, DQ_O;
    int failures = 0, check_count = 0;
    sdbba_top i_dut (.*);
    sdbba_ctl_model i_ctl (.*);
    always #25 CLK_SYS = ~CLK_SYS;
    task results;
        $display("checks %0d failures %0d", check_count, failures);
        if (failures == 0 && check_count > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask
    task chk(input logic [31:0] got, exp);
        check_count++;
        if (got !== exp) begin
            failures++;
            $display("[FAIL] %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task axw(input logic [3:0] a, input logic [31:0] d, input logic [1:0] r);
        int n;
        @(posedge CLK_SYS);
        {S_AXI_AWADDR, S_AXI_WDATA, S_AXI_AWVALID, S_AXI_WVALID, S_AXI_BREADY} <= {a, d, 3'h7};
        for (n = 0; n < 50 && !(n > 0 && S_AXI_BVALID); n++) begin
            @(posedge CLK_SYS);
            if (S_AXI_AWREADY) S_AXI_AWVALID <= 1'b0;
            if (S_AXI_WREADY) S_AXI_WVALID <= 1'b0;
        end
        S_AXI_BREADY <= 1'b0;
        if (n == 50) begin failures++; results(); end
        chk(S_AXI_BRESP, r);
    endtask
    task axr(input logic [3:0] a, input logic [31:0] d, input logic [1:0] r);
        int n;
        @(posedge CLK_SYS);
        {S_AXI_ARADDR, S_AXI_ARVALID, S_AXI_RREADY} <= {a, 2'h3};
        for (n = 0; n < 50 && !(n > 0 && S_AXI_RVALID); n++) begin
            @(posedge CLK_SYS);
            if (S_AXI_ARREADY) S_AXI_ARVALID <= 1'b0;
        end
        S_AXI_RREADY <= 1'b0;
        if (n == 50) begin failures++; results(); end
        chk(S_AXI_RDATA, d);
        chk(S_AXI_RRESP, r);
    endtask
    task nop(input int n);
        repeat (n) i_ctl.cmd(3'h7, 2'h0, 12'h0, 2'h0, 16'h0, 1'b0);
    endtask
    // Two-beat read; a floated beat compares as zero
    task rd2(input logic [11:0] a, input logic [1:0] m, input logic [16:0] e0, e1);
        i_ctl.cmd(sdbba_pkg::CMD_RD, 2'h0, a, m, 16'h0, 1'b0);
        nop(2);
        @(negedge CLK_SYS) chk({DQ_OE, DQ_O & {16{DQ_OE}}}, e0);
        nop(1);
        @(negedge CLK_SYS) chk({DQ_OE, DQ_O & {16{DQ_OE}}}, e1);
    endtask
    initial begin
        repeat (8) @(posedge CLK_SYS);
        RST_N <= 1'b1;
        axr(4'h0, 32'h23, sdbba_pkg::RESP_OKAY);
        axw(4'h0, 32'h21, sdbba_pkg::RESP_OKAY);
        axr(4'h0, 32'h21, sdbba_pkg::RESP_OKAY);
        axr(4'h8, 32'h0, sdbba_pkg::RESP_SLVERR);
        axw(4'h8, 32'h0, sdbba_pkg::RESP_SLVERR);
        $display("register test done");
        i_ctl.cmd(sdbba_pkg::CMD_ACT, 2'h0, 12'h005, 2'h0, 16'h0, 1'b0);
        i_ctl.cmd(sdbba_pkg::CMD_WR, 2'h0, 12'h004, 2'h0, 16'h1234, 1'b1);
        // Second write beat runs while bank 1 is precharged
        i_ctl.cmd(sdbba_pkg::CMD_PRE, 2'h1, 12'h0, 2'h0, 16'habcd, 1'b1);
        rd2(12'h004, 2'h0, 17'h11234, 17'h1abcd);
        rd2(12'h405, 2'h3, 17'h0, 17'h11234);
        rd2(12'h004, 2'h0, 17'h0, 17'h0);
        $display("burst test done");
        // One auto refresh with all banks closed, well inside one refresh period
        i_ctl.cmd(sdbba_pkg::CMD_REF, 2'h0, 12'h0, 2'h0, 16'h0, 1'b0);
        nop(1);
        // Clock gate drops with a no-op on the pins, so no self refresh is entered
        @(posedge CLK_SYS) CKE <= 1'b0;
        nop(2);
        axr(4'h4, 32'h0001_0020, sdbba_pkg::RESP_OKAY);
        @(posedge CLK_SYS) CKE <= 1'b1;
        $display("power test done");
        results();
    end
endmodule // test_sdram_bank_burst_access
